/* File: design/jpdr_pkg.sv */
// Function
// RULE1: instruction 0xC selects one-bit hold-in-reset chain; test controller not reset.
// RULE2: device reset asserted while hold-in-reset chain holds one, unlatched.
// RULE3: hold-in-reset bit shifts only in Shift-DR under its instruction.
// RULE4: reset stays asserted a fuse-dependent time-out after chain clears.
// RULE5: programmer resets device through chain before entering programming mode.
// RULE6: instruction 0x4 selects 16-bit unlock signature chain, shifted in Shift-DR.
// RULE7: Update-DR compares signature with 0xA370; equal enables programming.
// RULE8: signature register cleared on power-on reset; programmer clears on exit.
// RULE9: instruction 0x5 selects 15-bit programming command chain.
// RULE10: Capture-DR loads previous command result into command chain.
// RULE11: Shift-DR shifts result out on TDO, new command in from TDI.
// RULE12: Update-DR presents shifted command to flash control inputs.
// RULE13: Run-Test/Idle gives one execute pulse for applied command.
// RULE14: instruction 0x6 selects 1024-bit virtual page-load chain over 8-bit register.
// RULE15: each completed byte moves to page buffer during Shift-DR; no Update-DR.
// RULE16: page streaming used only when device is first in scan chain.
// RULE17: instruction 0x7 selects 1032-bit page-read chain, 8-bit register, no Capture-DR.
// RULE18: page-read Shift-DR fetches bytes and shifts them out, TDI ignored.
// RULE19: instruction register is four bits wide.
// RULE20: all chains shift least significant bit first.
// RULE21: no unlock match means commands never reach the flash.
package jpdr_pkg;
  // ------------------------------------------------------------
  // instruction codes
  // ------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [3:0] HOLD_IN_RESET_INSTR = 4'hC;
  localparam logic [3:0] PROGRAM_UNLOCK_INSTR = 4'h4;
  localparam logic [3:0] PROGRAM_COMMAND_INSTR = 4'h5;
  localparam logic [3:0] PAGE_STREAM_IN_INSTR = 4'h6;
  localparam logic [3:0] PAGE_STREAM_OUT_INSTR = 4'h7;
  // ------------------------------------------------------------
  // chain widths and values
  // ------------------------------------------------------------
  localparam int UNLOCK_W = 16;
  localparam logic [15:0] UNLOCK_SIGNATURE = 16'hA370;
  localparam logic [15:0] UNLOCK_RESET = 16'h0000;
  localparam int CMD_W = 15;
  localparam logic [14:0] CMD_RESET = 15'h0000;
  localparam int BYTE_W = 8;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam int PAGE_BYTES = 128;
  localparam int PAGE_ADDR_W = 7;
  // ------------------------------------------------------------
  // reset time-out, in system clocks, chosen by clock fuse
  // ------------------------------------------------------------
  localparam int TOUT_W = 16;
  localparam logic [15:0] TOUT_SHORT = 16'h0010;
  localparam logic [15:0] TOUT_LONG = 16'h0400;
  typedef enum logic [1:0] {JPDR_IDLE, JPDR_RUN} jpdr_tout_t;
endpackage

/* File: design/jpdr_sync.sv */
`timescale 1ns/10ps
module jpdr_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  always_comb begin
    next_meta = d_i;
    next_q = meta;
  end
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= next_meta;
      q_o <= next_q;
    end
  end
endmodule

/* File: design/jpdr_top.sv */
`timescale 1ns/10ps
module jpdr_top #(
  parameter int PAGE_BYTES = jpdr_pkg::PAGE_BYTES
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic tck_i,
  input wire logic tdi_i,
  input wire logic [3:0] ir_i,
  input wire logic capture_dr_i,
  input wire logic shift_dr_i,
  input wire logic update_dr_i,
  input wire logic run_idle_i,
  input wire logic fuse_long_tout_i,
  input wire logic [14:0] cmd_result_i,
  input wire logic [7:0] page_rd_data_i,
  output logic tdo_o,
  output logic device_reset_o,
  output logic program_unlock_instr_o,
  output logic [14:0] flash_cmd_o,
  output logic flash_cmd_valid_o,
  output logic flash_exec_o,
  output logic page_wr_o,
  output logic [6:0] page_wr_addr_o,
  output logic [7:0] page_wr_data_o,
  output logic page_rd_o,
  output logic [6:0] page_rd_addr_o
);
  // ------------------------------------------------------------
  // instruction decode (tck domain)
  // ------------------------------------------------------------
  logic sel_rst, sel_unl, sel_cmd, sel_pin, sel_pout;
  // RULE1 RULE19 decode
  assign sel_rst = (ir_i == jpdr_pkg::HOLD_IN_RESET_INSTR);
  // RULE6 decode
  assign sel_unl = (ir_i == jpdr_pkg::PROGRAM_UNLOCK_INSTR);
  // RULE9 decode
  assign sel_cmd = (ir_i == jpdr_pkg::PROGRAM_COMMAND_INSTR);
  // RULE14 decode
  assign sel_pin = (ir_i == jpdr_pkg::PAGE_STREAM_IN_INSTR);
  // RULE17 decode
  assign sel_pout = (ir_i == jpdr_pkg::PAGE_STREAM_OUT_INSTR);

  // ------------------------------------------------------------
  // tck-domain chains
  // ------------------------------------------------------------
  logic rst_bit, next_rst_bit;
  logic [15:0] unl_sr, next_unl_sr;
  logic unl_ok, next_unl_ok;
  logic [14:0] cmd_sr, next_cmd_sr;
  logic [14:0] cmd_app, next_cmd_app;
  logic cmd_tgl, next_cmd_tgl;
  logic exec_tgl, next_exec_tgl;
  logic [7:0] byte_sr, next_byte_sr;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [6:0] in_addr, next_in_addr;
  logic [6:0] out_addr, next_out_addr;
  logic wr_tgl, next_wr_tgl;
  logic rd_tgl, next_rd_tgl;
  logic [7:0] wr_byte, next_wr_byte;
  logic [6:0] wr_addr, next_wr_addr;
  logic in_shift_q, next_in_shift_q;
  logic idle_q, next_idle_q, rst_idle_edge;

  // flash-side words stand for many tck periods, so two flops without a handshake suffice
  logic [22:0] flash_q;
  logic [14:0] res_s;
  logic [7:0] rdat_s;
  jpdr_sync #(.W(23)) u_flash_sync (
    .clk_i(tck_i),
    .reset_n_i(reset_n_i),
    .d_i({cmd_result_i, page_rd_data_i}),
    .q_o(flash_q)
  );
  assign {res_s, rdat_s} = flash_q;

  always_comb begin
    next_rst_bit = rst_bit;
    next_unl_sr = unl_sr;
    next_unl_ok = unl_ok;
    next_cmd_sr = cmd_sr;
    next_cmd_app = cmd_app;
    next_cmd_tgl = cmd_tgl;
    next_exec_tgl = exec_tgl;
    next_byte_sr = byte_sr;
    next_bit_cnt = bit_cnt;
    next_in_addr = in_addr;
    next_out_addr = out_addr;
    next_wr_tgl = wr_tgl;
    next_rd_tgl = rd_tgl;
    next_wr_byte = wr_byte;
    next_wr_addr = wr_addr;
    next_in_shift_q = shift_dr_i;
    // RULE3 RULE20 reset shift
    if (sel_rst && shift_dr_i) begin
      next_rst_bit = tdi_i;
    end
    // RULE6 RULE20 signature shift
    if (sel_unl && shift_dr_i) begin
      next_unl_sr = {tdi_i, unl_sr[15:1]};
    end
    // RULE7 RULE21 signature compare
    if (sel_unl && update_dr_i) begin
      next_unl_ok = (unl_sr == jpdr_pkg::UNLOCK_SIGNATURE);
    end
    // RULE10 capture result
    if (sel_cmd && capture_dr_i) begin
      next_cmd_sr = res_s;
    end
    // RULE11 RULE20 command shift
    if (sel_cmd && shift_dr_i) begin
      next_cmd_sr = {tdi_i, cmd_sr[14:1]};
    end
    // RULE12 RULE21 apply command
    if (sel_cmd && update_dr_i && unl_ok) begin
      next_cmd_app = cmd_sr;
      next_cmd_tgl = ~cmd_tgl;
    end
    // RULE13 RULE21 execute pulse, one per idle entry
    if (sel_cmd && run_idle_i && !in_shift_q && update_dr_i == 1'b0 && unl_ok && rst_idle_edge) begin
      next_exec_tgl = ~exec_tgl;
    end
    // counters and byte register restart on every scan entry, so no stale bits leak out
    if (!shift_dr_i) begin
      next_bit_cnt = '0;
      next_byte_sr = jpdr_pkg::BYTE_RESET;
      next_in_addr = '0;
      next_out_addr = '0;
    end
    // RULE15 RULE20 page-in byte hand-off
    if (sel_pin && shift_dr_i) begin
      next_byte_sr = {tdi_i, byte_sr[7:1]};
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == jpdr_pkg::BIT_LAST && unl_ok) begin
        next_wr_byte = {tdi_i, byte_sr[7:1]};
        next_wr_addr = in_addr;
        next_in_addr = (in_addr == 7'(PAGE_BYTES - 1)) ? 7'h00 : in_addr + 7'h01;
        next_wr_tgl = ~wr_tgl;
      end
    end
    // RULE17 RULE18 page-out byte fetch, tdi ignored
    if (sel_pout && shift_dr_i) begin
      next_bit_cnt = bit_cnt + 3'h1;
      if (bit_cnt == jpdr_pkg::BIT_LAST) begin
        next_byte_sr = rdat_s;
        next_out_addr = (out_addr == 7'(PAGE_BYTES - 1)) ? 7'h00 : out_addr + 7'h01;
        next_rd_tgl = ~rd_tgl;
      end else begin
        next_byte_sr = {1'b0, byte_sr[7:1]};
      end
    end
  end

  // idle entry detector for the execute pulse
  assign next_idle_q = run_idle_i;
  assign rst_idle_edge = run_idle_i & ~idle_q;

  always_ff @(posedge tck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_bit <= 1'b0;
      // RULE8 power-on clear
      unl_sr <= jpdr_pkg::UNLOCK_RESET;
      unl_ok <= 1'b0;
      cmd_sr <= jpdr_pkg::CMD_RESET;
      cmd_app <= jpdr_pkg::CMD_RESET;
      cmd_tgl <= 1'b0;
      exec_tgl <= 1'b0;
      byte_sr <= jpdr_pkg::BYTE_RESET;
      bit_cnt <= '0;
      in_addr <= '0;
      out_addr <= '0;
      wr_tgl <= 1'b0;
      rd_tgl <= 1'b0;
      wr_byte <= jpdr_pkg::BYTE_RESET;
      wr_addr <= '0;
      in_shift_q <= 1'b0;
      idle_q <= 1'b0;
    end else begin
      rst_bit <= next_rst_bit;
      unl_sr <= next_unl_sr;
      unl_ok <= next_unl_ok;
      cmd_sr <= next_cmd_sr;
      cmd_app <= next_cmd_app;
      cmd_tgl <= next_cmd_tgl;
      exec_tgl <= next_exec_tgl;
      byte_sr <= next_byte_sr;
      bit_cnt <= next_bit_cnt;
      in_addr <= next_in_addr;
      out_addr <= next_out_addr;
      wr_tgl <= next_wr_tgl;
      rd_tgl <= next_rd_tgl;
      wr_byte <= next_wr_byte;
      wr_addr <= next_wr_addr;
      in_shift_q <= next_in_shift_q;
      idle_q <= next_idle_q;
    end
  end

  // ------------------------------------------------------------
  // tdo, updated on falling tck as a scan port does
  // ------------------------------------------------------------
  logic next_tdo;
  always_comb begin
    next_tdo = 1'b0;
    if (sel_rst) begin
      next_tdo = rst_bit;
    end else if (sel_unl) begin
      next_tdo = unl_sr[0];
    end else if (sel_cmd) begin
      // RULE11 result out lsb first
      next_tdo = cmd_sr[0];
    end else if (sel_pin || sel_pout) begin
      next_tdo = byte_sr[0];
    end
  end
  always_ff @(negedge tck_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tdo_o <= 1'b0;
    end else begin
      tdo_o <= next_tdo;
    end
  end

  // ------------------------------------------------------------
  // crossing to the system clock
  // ------------------------------------------------------------
  logic [6:0] sync_q;
  // the reset level crosses too, so device reset lags the chain by the synchroniser
  jpdr_sync #(.W(7)) u_sync (
    .clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .d_i({rst_bit, unl_ok, cmd_tgl, exec_tgl, wr_tgl, rd_tgl, fuse_long_tout_i}),
    .q_o(sync_q)
  );
  logic rst_s, ok_s, cmd_s, exe_s, wr_s, rd_s, fuse_s;
  assign {rst_s, ok_s, cmd_s, exe_s, wr_s, rd_s, fuse_s} = sync_q;

  // ------------------------------------------------------------
  // system side: reset time-out and flash strobes
  // ------------------------------------------------------------
  jpdr_pkg::jpdr_tout_t st, next_st;
  logic [15:0] tout, next_tout;
  logic [3:0] tgl_q, next_tgl_q;
  logic next_dev_rst, next_ok, next_cval, next_exec, next_wr, next_rd;
  logic [14:0] next_fcmd;
  logic [7:0] next_wdata;
  logic [6:0] next_waddr, next_raddr;

  always_comb begin
    next_st = st;
    next_tout = tout;
    next_tgl_q = {cmd_s, exe_s, wr_s, rd_s};
    next_dev_rst = 1'b0;
    unique case (st)
      jpdr_pkg::JPDR_IDLE: begin
        if (rst_s) begin
          next_st = jpdr_pkg::JPDR_RUN;
        end
      end
      jpdr_pkg::JPDR_RUN: begin
        // RULE4 fuse-dependent time-out
        if (rst_s) begin
          next_tout = fuse_s ? jpdr_pkg::TOUT_LONG : jpdr_pkg::TOUT_SHORT;
        end else if (tout == '0) begin
          next_st = jpdr_pkg::JPDR_IDLE;
        end else begin
          next_tout = tout - 16'h0001;
        end
      end
      default: next_st = jpdr_pkg::JPDR_IDLE;
    endcase
    next_dev_rst = rst_s || (next_st == jpdr_pkg::JPDR_RUN);
    next_ok = ok_s;
    // RULE12 RULE21 flash inputs only while unlocked
    next_cval = ok_s;
    next_fcmd = !ok_s ? jpdr_pkg::CMD_RESET : ((cmd_s != tgl_q[3]) ? cmd_app : flash_cmd_o);
    // RULE13 one system clock execute pulse
    next_exec = ok_s && (exe_s != tgl_q[2]);
    // RULE15 page buffer write
    next_wr = (wr_s != tgl_q[1]);
    next_wdata = next_wr ? wr_byte : page_wr_data_o;
    next_waddr = next_wr ? wr_addr : page_wr_addr_o;
    // RULE18 page fetch strobe
    next_rd = ok_s && (rd_s != tgl_q[0]);
    // fetch address is sampled freely: it moves once per 8 tck, so a torn sample settles before use
    next_raddr = out_addr;
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= jpdr_pkg::JPDR_IDLE;
      tout <= '0;
      tgl_q <= '0;
      device_reset_o <= 1'b0;
      program_unlock_instr_o <= 1'b0;
      flash_cmd_valid_o <= 1'b0;
      flash_cmd_o <= jpdr_pkg::CMD_RESET;
      flash_exec_o <= 1'b0;
      page_wr_o <= 1'b0;
      page_wr_data_o <= jpdr_pkg::BYTE_RESET;
      page_wr_addr_o <= '0;
      page_rd_o <= 1'b0;
      page_rd_addr_o <= '0;
    end else begin
      st <= next_st;
      tout <= next_tout;
      tgl_q <= next_tgl_q;
      // RULE2 reset held while chain is one
      device_reset_o <= next_dev_rst;
      program_unlock_instr_o <= next_ok;
      flash_cmd_valid_o <= next_cval;
      flash_cmd_o <= next_fcmd;
      flash_exec_o <= next_exec;
      page_wr_o <= next_wr;
      page_wr_data_o <= next_wdata;
      page_wr_addr_o <= next_waddr;
      page_rd_o <= next_rd;
      page_rd_addr_o <= next_raddr;
    end
  end
endmodule

/* File: dv/jpdr_top_monitor.sv */
`timescale 1ns/10ps
module jpdr_top_monitor (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic device_reset_o,
  input wire logic program_unlock_instr_o,
  input wire logic [14:0] flash_cmd_o,
  input wire logic flash_cmd_valid_o,
  input wire logic flash_exec_o,
  input wire logic page_wr_o,
  input wire logic page_rd_o
);
  // cycles that device reset has been high so far
  logic [15:0] hi_cnt;
  logic [15:0] next_hi_cnt;
  always_comb begin
    next_hi_cnt = device_reset_o ? hi_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      hi_cnt <= 16'h0000;
    end else begin
      hi_cnt <= next_hi_cnt;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_reset_holds: assert property ($rose(device_reset_o) |=> device_reset_o[*8])
    else $error("device reset too short");
  a_tout_min: assert property ($fell(device_reset_o) |-> hi_cnt >= jpdr_pkg::TOUT_SHORT)
    else $error("reset released before time-out");
  a_cmd_locked: assert property (!program_unlock_instr_o |-> flash_cmd_o == 15'h0000 && !flash_cmd_valid_o)
    else $error("command applied while locked");
  a_exec_locked: assert property (flash_exec_o |-> program_unlock_instr_o)
    else $error("execute while locked");
  a_exec_single: assert property (flash_exec_o |=> !flash_exec_o[*3])
    else $error("execute pulse too long");
  a_wr_single: assert property (page_wr_o |=> !page_wr_o[*3])
    else $error("page write too close");
  a_wr_locked: assert property (page_wr_o |-> program_unlock_instr_o)
    else $error("page write while locked");
  a_rd_single: assert property (page_rd_o |=> !page_rd_o[*3])
    else $error("page read too close");
  a_rd_locked: assert property (page_rd_o |-> program_unlock_instr_o)
    else $error("page read while locked");
endmodule
bind jpdr_top jpdr_top_monitor u_mon (
  .sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i),
  .device_reset_o(device_reset_o),
  .program_unlock_instr_o(program_unlock_instr_o),
  .flash_cmd_o(flash_cmd_o),
  .flash_cmd_valid_o(flash_cmd_valid_o),
  .flash_exec_o(flash_exec_o),
  .page_wr_o(page_wr_o),
  .page_rd_o(page_rd_o)
);

/* File: dv/jpdr_prog_model.sv */
`timescale 1ns/10ps
module jpdr_prog_model (
  input wire logic tdo_i,
  output logic tck_o,
  output logic tdi_o,
  output logic [3:0] ir_o,
  output logic capture_o,
  output logic shift_o,
  output logic update_o,
  output logic idle_o
);
  // scan clock stands low outside frames
  initial begin
    {tck_o, tdi_o, ir_o, capture_o, shift_o, update_o, idle_o} = '0;
  end
  task automatic tick();
    #6 tck_o = 1'b1;
    #6 tck_o = 1'b0;
  endtask
  task automatic scan(input logic [3:0] ir, input logic [31:0] din, input int n, input bit cap,
      output logic [31:0] dout);
    dout = '0;
    ir_o = ir;
    capture_o = cap;
    if (cap) tick();
    capture_o = 1'b0;
    shift_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      tdi_o = din[i];
      #6 tck_o = 1'b1;
      dout[i] = tdo_i;
      #6 tck_o = 1'b0;
    end
    shift_o = 1'b0;
    // released line shows the inverse, not the last bit
    tdi_o = ~tdi_o;
  endtask
  task automatic step(input bit upd, input int n);
    update_o = upd;
    idle_o = !upd;
    tick();
    update_o = 1'b0;
    repeat (n - 1) tick();
    idle_o = 1'b0;
  endtask
endmodule

/* File: dv/jpdr_top_tb.sv */
`timescale 1ns/10ps
module jpdr_top_tb;
  logic sys_clk_i, reset_n_i, tck_i, tdi_i, capture_dr_i, shift_dr_i, update_dr_i, run_idle_i;
  logic fuse_long_tout_i, tdo_o, device_reset_o, program_unlock_instr_o, flash_cmd_valid_o, flash_exec_o;
  logic page_wr_o, page_rd_o;
  logic [3:0] ir_i;
  logic [14:0] cmd_result_i, flash_cmd_o;
  logic [7:0] page_rd_data_i, page_wr_data_o, wr_last;
  logic [6:0] page_wr_addr_o, page_rd_addr_o, wr_addr;
  logic [31:0] d;
  int fails = 0;
  int total_checks = 0;
  int exec_n = 0;
  int wr_n = 0;
  int rd_n = 0;
  jpdr_top uut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .tck_i(tck_i), .tdi_i(tdi_i),
    .ir_i(ir_i), .capture_dr_i(capture_dr_i), .shift_dr_i(shift_dr_i), .update_dr_i(update_dr_i),
    .run_idle_i(run_idle_i), .fuse_long_tout_i(fuse_long_tout_i), .cmd_result_i(cmd_result_i),
    .page_rd_data_i(page_rd_data_i), .tdo_o(tdo_o), .device_reset_o(device_reset_o),
    .program_unlock_instr_o(program_unlock_instr_o), .flash_cmd_o(flash_cmd_o), .flash_cmd_valid_o(flash_cmd_valid_o),
    .flash_exec_o(flash_exec_o), .page_wr_o(page_wr_o), .page_wr_addr_o(page_wr_addr_o),
    .page_wr_data_o(page_wr_data_o), .page_rd_o(page_rd_o), .page_rd_addr_o(page_rd_addr_o));
  jpdr_prog_model m (.tdo_i(tdo_o), .tck_o(tck_i), .tdi_o(tdi_i), .ir_o(ir_i),
    .capture_o(capture_dr_i), .shift_o(shift_dr_i), .update_o(update_dr_i), .idle_o(run_idle_i));
  // page memory answers from the address it is shown
  assign page_rd_data_i = {1'b1, page_rd_addr_o} ^ 8'h3C;
  always @(negedge sys_clk_i) begin
    if (flash_exec_o === 1'b1) exec_n++;
    if (page_rd_o === 1'b1) rd_n++;
    if (page_wr_o === 1'b1) begin
      wr_n++;
      wr_last = page_wr_data_o;
      wr_addr = page_wr_addr_o;
    end
  end
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic wait_sys(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_hold(input logic fuse, input int tout);
    int n;
    @(negedge sys_clk_i);
    fuse_long_tout_i = fuse;
    m.scan(jpdr_pkg::HOLD_IN_RESET_INSTR, 32'h1, 1, 1'b0, d);
    wait_sys(6);
    chk("device_reset_o", 1, device_reset_o);
    m.step(1'b0, 3);
    wait_sys(6);
    chk("reset after idle", 1, device_reset_o);
    m.scan(jpdr_pkg::HOLD_IN_RESET_INSTR, 32'h0, 1, 1'b0, d);
    n = 0;
    while (device_reset_o === 1'b1 && n < tout + 40) begin
      wait_sys(1);
      n++;
    end
    chk("reset time-out", 1, n >= tout && n <= tout + 12);
  endtask
  task automatic t_locked();
    m.scan(jpdr_pkg::PROGRAM_COMMAND_INSTR, 32'h2311, 15, 1'b1, d);
    m.step(1'b1, 1);
    m.step(1'b0, 2);
    m.scan(jpdr_pkg::PAGE_STREAM_IN_INSTR, 32'hBEEF, 16, 1'b0, d);
    wait_sys(8);
    chk("locked valid", 0, flash_cmd_valid_o);
    chk("locked exec", 0, exec_n);
    chk("locked writes", 0, wr_n);
  endtask
  task automatic t_unlock(input logic [15:0] sig, input logic exp);
    m.scan(jpdr_pkg::PROGRAM_UNLOCK_INSTR, {16'h0000, sig}, 16, 1'b0, d);
    m.step(1'b1, 1);
    wait_sys(8);
    chk("program_unlock_instr_o", exp, program_unlock_instr_o);
  endtask
  task automatic t_cmd();
    int e;
    @(negedge sys_clk_i);
    cmd_result_i = 15'h5A3C;
    m.step(1'b0, 2);
    m.scan(jpdr_pkg::PROGRAM_COMMAND_INSTR, 32'h2311, 15, 1'b1, d);
    chk("captured result", 15'h5A3C, d[14:0]);
    m.step(1'b1, 1);
    wait_sys(8);
    chk("flash_cmd_o", 15'h2311, flash_cmd_o);
    chk("flash_cmd_valid_o", 1, flash_cmd_valid_o);
    e = exec_n;
    m.step(1'b0, 3);
    wait_sys(8);
    chk("exec pulses", e + 1, exec_n);
  endtask
  task automatic t_page_in();
    m.scan(jpdr_pkg::PAGE_STREAM_IN_INSTR, 32'h097EC3A5, 28, 1'b0, d);
    wait_sys(8);
    chk("page writes", 3, wr_n);
    chk("last byte", 8'h7E, wr_last);
    chk("last addr", 7'h02, wr_addr);
    m.step(1'b1, 1);
    wait_sys(8);
    chk("writes after update", 3, wr_n);
  endtask
  task automatic t_page_out();
    m.scan(jpdr_pkg::PAGE_STREAM_OUT_INSTR, 32'hFFFFFFFF, 24, 1'b0, d);
    chk("filler byte", 8'h00, d[7:0]);
    chk("byte 0", 8'hBC, d[15:8]);
    chk("byte 1", 8'hBD, d[23:16]);
    wait_sys(8);
    chk("page reads", 3, rd_n);
  endtask
  initial begin
    reset_n_i = 1'b0;
    fuse_long_tout_i = 1'b0;
    cmd_result_i = 15'h0000;
    m.tick();
    m.tick();
    repeat (8) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    wait_sys(4);
    chk("enable after reset", 0, program_unlock_instr_o);
    t_hold(1'b0, 16);
    t_hold(1'b1, 1024);
    t_locked();
    t_unlock(16'hA371, 1'b0);
    t_unlock(16'hA370, 1'b1);
    t_cmd();
    t_page_in();
    t_page_out();
    t_unlock(16'h0000, 1'b0);
    chk("cmd after exit", 0, flash_cmd_o);
    close_out();
  end
  initial begin
    #400000;
    fails++;
    close_out();
  end
endmodule
